/* File: hw/cac_assess_ctrl.sv */
`timescale 1ns/1ps
module cac_assess_ctrl
  import cac_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  // receiver status
  input wire logic [4:0] trxState,
  input wire logic basicMode,
  input wire logic rxListening,
  input wire logic rxBusy,
  input wire logic shrDetected,
  input wire logic frameEnd,
  // signal measurements
  input wire logic [7:0] energyLevel,
  input wire logic carrierDetect,
  // results
  output logic measurementCompleteEvent,
  output logic [4:0] channelSel
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  cac_state_e state_r;
  cac_state_e state_nxt;
  logic done_r;
  logic done_nxt;
  logic idle_r;
  logic idle_nxt;
  logic evt_r;
  logic evt_nxt;
  logic winEnergy_r;
  logic winEnergy_nxt;
  logic winCarrier_r;
  logic winCarrier_nxt;

  logic [1:0] mode_r;
  logic [1:0] mode_nxt;
  logic [4:0] chan_r;
  logic [4:0] chan_nxt;
  logic [4:0] thres_r;
  logic [4:0] thres_nxt;
  logic [2:0] thresRes_r;
  logic [2:0] thresRes_nxt;
  logic [7:0] rdData_r;
  logic [7:0] rdData_nxt;

  logic edRan_r;
  logic edRan_nxt;
  logic edAccum_r;
  logic edAccum_nxt;
  logic edResult_r;
  logic edResult_nxt;

  logic request;
  logic [1:0] algoSel;
  logic inReceive;
  logic energyNow;
  logic immEnergy;
  logic listenStart;
  logic listenRunning;
  logic listenExpire;
  logic edStart;
  logic edRunning;
  logic edExpire;

  cac_verdict_if vif ();

  ////////////////////////////////////////////////////////////////////////////
  // request decode and instantaneous decisions
  // the request bit is never stored, so a read can't show it pending
  assign request = regWrite && (regAddr == ADDR_CTRL) &&
    regWrData[BIT_REQ];
  assign inReceive = basicMode && (rxListening || rxBusy);
  // energy level counts dB above the floor, so the floor term cancels
  assign energyNow = energyLevel > {2'h0, thres_r, 1'b0};
  assign immEnergy = edRan_r ? edResult_r : energyNow;

  ////////////////////////////////////////////////////////////////////////////
  // timers: listening window and automatic energy run
  // a sync landing on the frame end belongs to the next frame, so the end
  // re-arms the run in the same cycle
  assign edStart = shrDetected && rxBusy &&
    (frameEnd || (!edRan_r && !edRunning));

  cac_interval_timer #(
    .LOAD(LISTEN_CYCLES)
  ) u_listen_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(listenStart),
    .abort(1'b0),
    .running(listenRunning),
    .expire(listenExpire)
  );

  cac_interval_timer #(
    .LOAD(ED_RUN_CYCLES)
  ) u_ed_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(edStart),
    .abort(frameEnd),
    .running(edRunning),
    .expire(edExpire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decision inputs
  // the request write carries its own mode, which must decide at once
  assign algoSel = request ? regWrData[MODE_MSB:MODE_LSB] : mode_r;
  assign vif.algo = cac_algo_e'(algoSel);

  always_comb begin
    if (request) begin
      vif.energyBusy = immEnergy;
      vif.carrierBusy = carrierDetect;
    end else if (state_r == ST_LISTEN) begin
      vif.energyBusy = winEnergy_r || energyNow;
      vif.carrierBusy = winCarrier_r || carrierDetect;
    end else begin
      vif.energyBusy = edAccum_r || energyNow;
      vif.carrierBusy = carrierDetect;
    end
  end

  cac_verdict u_verdict (
    .vif(vif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // automatic energy run bookkeeping
  always_comb begin
    edRan_nxt = edRan_r;
    edAccum_nxt = edAccum_r;
    edResult_nxt = edResult_r;
    if (frameEnd) begin
      edRan_nxt = 1'b0;
    end
    // a sync arriving with the frame end still counts for the next frame
    if (edStart) begin
      edRan_nxt = 1'b1;
      edAccum_nxt = 1'b0;
    end else if (edRunning) begin
      edAccum_nxt = edAccum_r || energyNow;
    end
    if (edExpire) begin
      edResult_nxt = edAccum_r || energyNow;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      edRan_r <= 1'b0;
      edAccum_r <= 1'b0;
      edResult_r <= 1'b0;
    end else begin
      edRan_r <= edRan_nxt;
      edAccum_r <= edAccum_nxt;
      edResult_r <= edResult_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assessment sequencer
  always_comb begin
    state_nxt = state_r;
    done_nxt = done_r;
    idle_nxt = idle_r;
    evt_nxt = 1'b0;
    winEnergy_nxt = winEnergy_r;
    winCarrier_nxt = winCarrier_r;
    listenStart = 1'b0;

    case (state_r)
      ST_IDLE: begin
        state_nxt = ST_IDLE;
      end
      ST_LISTEN: begin
        winEnergy_nxt = winEnergy_r || energyNow;
        winCarrier_nxt = winCarrier_r || carrierDetect;
        if (listenExpire) begin
          done_nxt = 1'b1;
          idle_nxt = vif.channelIdle;
          evt_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      ST_WAIT_ED: begin
        // a frame cut short ends the run, so the wait ends with it
        if (edExpire || frameEnd || !edRunning) begin
          done_nxt = 1'b1;
          idle_nxt = vif.channelIdle;
          evt_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase

    // a fresh request restarts everything; a completion in the same cycle
    // still keeps its event pulse
    if (request) begin
      done_nxt = 1'b0;
      idle_nxt = 1'b0;
      winEnergy_nxt = 1'b0;
      winCarrier_nxt = 1'b0;
      if (!inReceive) begin
        done_nxt = 1'b1;
        evt_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end else if (rxListening) begin
        listenStart = 1'b1;
        state_nxt = ST_LISTEN;
      end else if ((algoSel == ALG_CS_ONLY) || !edRunning) begin
        done_nxt = 1'b1;
        idle_nxt = vif.channelIdle;
        evt_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end else begin
        // early pulse while the flag is still 0; the real one follows
        evt_nxt = 1'b1;
        state_nxt = ST_WAIT_ED;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      done_r <= 1'b0;
      idle_r <= 1'b0;
      evt_r <= 1'b0;
      winEnergy_r <= 1'b0;
      winCarrier_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      done_r <= done_nxt;
      idle_r <= idle_nxt;
      evt_r <= evt_nxt;
      winEnergy_r <= winEnergy_nxt;
      winCarrier_r <= winCarrier_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file
  always_comb begin
    mode_nxt = mode_r;
    chan_nxt = chan_r;
    thres_nxt = thres_r;
    thresRes_nxt = thresRes_r;
    rdData_nxt = rdData_r;

    // status register takes no writes at all
    if (regWrite) begin
      case (regAddr)
        ADDR_CTRL: begin
          mode_nxt = regWrData[MODE_MSB:MODE_LSB];
          chan_nxt = regWrData[CHAN_MSB:0];
        end
        ADDR_THRES: begin
          thres_nxt = regWrData[THR_MSB:0];
          thresRes_nxt = regWrData[7:THR_RES_LSB];
        end
        default: begin
          chan_nxt = chan_r;
        end
      endcase
    end

    if (regRead) begin
      case (regAddr)
        ADDR_STATUS: begin
          rdData_nxt = {done_r, idle_r, 1'b0, trxState};
        end
        ADDR_CTRL: begin
          rdData_nxt = {1'b0, mode_r, chan_r};
        end
        ADDR_THRES: begin
          rdData_nxt = {thresRes_r, thres_r};
        end
        default: begin
          rdData_nxt = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= CTRL_RESET[MODE_MSB:MODE_LSB];
      chan_r <= CTRL_RESET[CHAN_MSB:0];
      thres_r <= THRES_RESET[THR_MSB:0];
      thresRes_r <= THRES_RESET[7:THR_RES_LSB];
      rdData_r <= 8'h00;
    end else begin
      mode_r <= mode_nxt;
      chan_r <= chan_nxt;
      thres_r <= thres_nxt;
      thresRes_r <= thresRes_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign regRdData = rdData_r;
  assign measurementCompleteEvent = evt_r;
  assign channelSel = chan_r;

endmodule

/* File: hw/cac_interval_timer.sv */
`timescale 1ns/1ps
module cac_interval_timer
  import cac_pkg::*;
#(
  parameter logic [TMR_W-1:0] LOAD = 12'h001
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic abort,
  // status
  output logic running,
  output logic expire
);

  logic [TMR_W-1:0] count_r;
  logic [TMR_W-1:0] count_nxt;

  // expire marks the last counted cycle, so a start at edge 0 lets the
  // consumer act at edge LOAD
  assign running = (count_r != '0);
  assign expire = (count_r == TMR_W'(1)) && !abort && !start;

  always_comb begin
    count_nxt = count_r;
    if (start) begin
      count_nxt = LOAD;
    end else if (abort) begin
      count_nxt = '0;
    end else if (running) begin
      count_nxt = count_r - TMR_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

endmodule

/* File: hw/cac_verdict.sv */
`timescale 1ns/1ps
module cac_verdict
  import cac_pkg::*;
(
  // decision inputs and result
  cac_verdict_if.judge vif
);

  logic busy;

  always_comb begin
    case (vif.algo)
      ALG_CS_OR_ED: busy = vif.carrierBusy || vif.energyBusy;
      ALG_ED_ONLY: busy = vif.energyBusy;
      ALG_CS_ONLY: busy = vif.carrierBusy;
      ALG_CS_AND_ED: busy = vif.carrierBusy && vif.energyBusy;
      default: busy = 1'b1;
    endcase
  end

  assign vif.channelIdle = !busy;

endmodule

/* File: shared/cac_pkg.sv */
// How it works
// - an accepted request clears the complete and idle flags first.
// - complete flag becomes 1 when a measurement cycle ends, 0 meanwhile.
// - idle flag is 1 when nothing was detected, 0 when busy.
// - energy algorithm calls busy when power exceeds the threshold level.
// - carrier algorithm calls busy on a detected compliant modulated signal.
// - a finished manual assessment raises the complete event, number 4.
// - request outside basic receive states completes at once, unmeasured.
// - request during an energy run may signal at once, then again later.
// - in listening state the result appears 140 us after the request.
// - receiving in modes 0, 1, 3 waits for a running energy run.
// - receiving in mode 2 the result is given at once.
// - one automatic 8 symbol energy run per frame, started after sync.
// - host keeps receiver listening so the measurement lasts 8 symbols; the listening window here spans the full 140 us.
// - writing 1 to bit 7 of 0x08 starts a request, then self-clears.
// - bits 6:5 pick OR, energy, carrier, or AND algorithm.
// - 0x01 shows complete in 7, idle in 6, state in 4:0.
// - threshold is floor plus twice the five bit field in dB.
// - threshold field sits in bits 4:0 of 0x09; 7:5 reserved.
package cac_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [5:0] ADDR_STATUS = 6'h01;
  localparam logic [5:0] ADDR_CTRL = 6'h08;
  localparam logic [5:0] ADDR_THRES = 6'h09;

  localparam int BIT_DONE = 7;
  localparam int BIT_IDLE = 6;
  localparam int BIT_REQ = 7;
  localparam int MODE_LSB = 5;
  localparam int MODE_MSB = 6;
  localparam int CHAN_MSB = 4;
  localparam int THR_MSB = 4;
  localparam int THR_RES_LSB = 5;

  localparam logic [7:0] CTRL_RESET = 8'h20;
  localparam logic [7:0] THRES_RESET = 8'hC7;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing at 25 MHz
  localparam int CLK_PERIOD_NS = 40;
  localparam int LISTEN_RESULT_NS = 140000;
  localparam int ED_RUN_NS = 128000;
  localparam int TMR_W = 12;
  localparam logic [TMR_W-1:0] LISTEN_CYCLES =
    TMR_W'((LISTEN_RESULT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [TMR_W-1:0] ED_RUN_CYCLES =
    TMR_W'((ED_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    ALG_CS_OR_ED = 2'h0,
    ALG_ED_ONLY = 2'h1,
    ALG_CS_ONLY = 2'h2,
    ALG_CS_AND_ED = 2'h3
  } cac_algo_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_LISTEN = 3'h2,
    ST_WAIT_ED = 3'h4
  } cac_state_e;

endpackage

/* File: shared/cac_verdict_if.sv */
`timescale 1ns/1ps
interface cac_verdict_if;
  import cac_pkg::*;

  cac_algo_e algo;
  logic energyBusy;
  logic carrierBusy;
  logic channelIdle;

  modport ctrl (output algo, output energyBusy, output carrierBusy,
    input channelIdle);
  modport judge (input algo, input energyBusy, input carrierBusy,
    output channelIdle);
endinterface

/* File: testbench/cac_assess_ctrl_properties.sv */
`timescale 1ns/1ps
module cac_assess_ctrl_properties
  import cac_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  // receiver status and result
  input wire logic [4:0] trxState,
  input wire logic basicMode,
  input wire logic rxListening,
  input wire logic rxBusy,
  input wire logic measurementCompleteEvent
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic req, reqL, stRd, wCtl, wThr;
  logic [TMR_W-1:0] lCnt_r, lCnt_nxt;
  assign req = regWrite && regAddr == ADDR_CTRL && regWrData[BIT_REQ];
  assign reqL = req && basicMode && rxListening && !rxBusy;
  assign stRd = regRead && regAddr == ADDR_STATUS;
  assign wCtl = regWrite && regAddr == ADDR_CTRL;
  assign wThr = regWrite && regAddr == ADDR_THRES;
  ////////////////////////////////////////////////////////////////////////////
  // age of a listening request; any new request restarts or drops it
  always_comb begin
    lCnt_nxt = lCnt_r;
    if (req)
      lCnt_nxt = reqL ? 12'h001 : 12'h000;
    else if (measurementCompleteEvent)
      lCnt_nxt = 12'h000;
    else if (lCnt_r != 12'h000)
      lCnt_nxt = lCnt_r + 12'h001;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      lCnt_r <= 12'h000;
    else
      lCnt_r <= lCnt_nxt;
  end
  ////////////////////////////////////////////////////////////////////////////
  stat_fields_a:
    assert property (stRd |=> !regRdData[5] &&
      regRdData[4:0] == $past(trxState)) else $error("status fields");
  req_clear_a:
    assert property (regRead && regAddr == ADDR_CTRL |=> !regRdData[7])
    else $error("request bit reads one");
  ctrl_back_a:
    assert property (wCtl ##2 regRead && regAddr == ADDR_CTRL |=>
      regRdData[6:0] == 7'($past(regWrData, 3))) else $error("ctrl back");
  thr_back_a:
    assert property (wThr ##2 regRead && regAddr == ADDR_THRES |=>
      regRdData[4:0] == 5'($past(regWrData, 3))) else $error("thres back");
  flags_clr_a:
    assert property (reqL ##4 stRd |=> regRdData[7:6] == 2'h0)
    else $error("flags not cleared");
  offrx_done_a:
    assert property (req && !basicMode |=> measurementCompleteEvent)
    else $error("no event off receive");
  cs_now_a:
    assert property (req && basicMode && rxBusy && regWrData[6:5] == 2'h2
      |=> measurementCompleteEvent) else $error("carrier result late");
  // the count is 1 just after the request edge and the pulse is seen one
  // edge after its launch, so the full window reads one higher
  listen_time_a:
    assert property (measurementCompleteEvent && lCnt_r != 12'h000 |->
      lCnt_r == LISTEN_CYCLES + 12'h001) else $error("listen time wrong");
  cover property (measurementCompleteEvent && lCnt_r == LISTEN_CYCLES);
  cover property (req && !basicMode);
  cover property (req && rxBusy ##1 measurementCompleteEvent);
endmodule

bind cac_assess_ctrl cac_assess_ctrl_properties u_prop (.*);

/* File: testbench/cac_host_model.sv */
`timescale 1ns/1ps
module cac_host_model
  import cac_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // register port
  output logic regWrite,
  output logic regRead,
  output logic [5:0] regAddr,
  output logic [7:0] regWrData,
  input wire logic [7:0] regRdData
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 6'h00;
    regWrData = 8'h00;
  end
  // one idle edge first so back to back calls never re-drive a strobe
  // in the same step; released lines are inverted, not left stale
  task automatic acc(input logic w, input logic [5:0] a,
    input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    #1;
    regWrite = w;
    regRead = !w;
    regAddr = a;
    regWrData = d;
    @(posedge clk_sys);
    #1;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
    q = regRdData;
  endtask
endmodule

/* File: testbench/clear_channel_assessment_ctrl_bench.sv */
`timescale 1ns/1ps
module clear_channel_assessment_ctrl_bench
  import cac_pkg::*;
;
  logic clk_sys, rst_n, regWrite, regRead, basicMode, rxListening;
  logic rxBusy, shrDetected, frameEnd, carrierDetect;
  logic measurementCompleteEvent;
  logic [5:0] regAddr;
  logic [7:0] regWrData, regRdData, energyLevel, rd, ex;
  logic [4:0] trxState, channelSel;
  logic [31:0] seed = 32'h00000028;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int reqCyc, shrCyc;
  int evq[$];

  cac_assess_ctrl dut (.*);
  cac_host_model host (.*);

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // event times are logged as absolute cycles so latency needs no polling
  always @(posedge clk_sys) begin
    if (measurementCompleteEvent === 1'b1)
      evq.push_back(cyc);
    if (regWrite && regAddr == ADDR_CTRL && regWrData[BIT_REQ])
      reqCyc = cyc;
    if (shrDetected || frameEnd)
      shrCyc = cyc;
    cyc <= cyc + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic idle(int m, int e, int c, int t);
    logic ed;
    ed = e > 2 * t;
    case (m)
      0: return !(ed || c);
      1: return !ed;
      2: return !c;
      default: return !(ed && c);
    endcase
  endfunction
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic ev(input int base, input int lo, input int hi);
    int got;
    for (int n = 0; n < 4000 && evq.size() == 0; n++) begin
      @(posedge clk_sys);
      #1;
    end
    got = evq.size() ? evq.pop_front() - base : -1;
    compares++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("ERROR %0t lat %0h exp %0h", $time, got, lo);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [7:0] e);
    host.acc(1'b0, a, 8'h00, rd);
    cmp(rd, e);
  endtask
  task automatic pulse(input logic f);
    @(posedge clk_sys);
    #1;
    shrDetected = !f;
    frameEnd = f;
    @(posedge clk_sys);
    #1;
    shrDetected = 1'b0;
    frameEnd = 1'b0;
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int m, t, ch;
    rst_n = 1'b0;
    basicMode = 1'b1;
    rxListening = 1'b1;
    rxBusy = 1'b0;
    shrDetected = 1'b0;
    frameEnd = 1'b0;
    carrierDetect = 1'b0;
    energyLevel = 8'h00;
    trxState = 5'h06;
    repeat (2) @(posedge clk_sys);
    #1;
    rst_n = 1'b1;
    rdc(ADDR_CTRL, CTRL_RESET);
    rdc(ADDR_THRES, THRES_RESET);
    wr(ADDR_STATUS, 8'hFF);
    rdc(ADDR_STATUS, {3'h0, trxState});
    rdc(6'h3F, UNMAPPED_READ);
    for (int i = 0; i < 8; i++) begin
      m = i % 4;
      t = rnd() % 32;
      ch = rnd() % 32;
      wr(ADDR_THRES, 8'(t));
      rdc(ADDR_THRES, 8'(t));
      energyLevel = 8'(rnd() % 85);
      carrierDetect = 1'(rnd());
      trxState = 5'(rnd());
      evq.delete();
      wr(ADDR_CTRL, {1'b1, 2'(m), 5'(ch)});
      rdc(ADDR_CTRL, {1'b0, 2'(m), 5'(ch)});
      cmp({3'h0, channelSel}, 8'(ch));
      rdc(ADDR_STATUS, {3'h0, trxState});
      // latency runs to the edge that first sees the pulse, one past launch
      ev(reqCyc, LISTEN_CYCLES + 1, LISTEN_CYCLES + 1);
      ex = {1'b1, idle(m, energyLevel, carrierDetect, t), 1'b0, trxState};
      rdc(ADDR_STATUS, ex);
    end
    basicMode = 1'b0;
    wr(ADDR_CTRL, 8'hA0);
    ev(reqCyc, 1, 1);
    rdc(ADDR_STATUS, {3'h4, trxState});
    basicMode = 1'b1;
    rxListening = 1'b0;
    rxBusy = 1'b1;
    carrierDetect = 1'b1;
    energyLevel = 8'h00;
    pulse(1'b0);
    wr(ADDR_CTRL, 8'hC0);
    ev(reqCyc, 1, 1);
    rdc(ADDR_STATUS, {3'h4, trxState});
    wr(ADDR_CTRL, 8'hA0);
    ev(reqCyc, 1, 1);
    rdc(ADDR_STATUS, {3'h0, trxState});
    ev(shrCyc, ED_RUN_CYCLES + 1, ED_RUN_CYCLES + 1);
    rdc(ADDR_STATUS, {3'h6, trxState});
    // a second sync in the same frame must not open another run
    pulse(1'b0);
    wr(ADDR_CTRL, 8'hA0);
    ev(reqCyc, 1, 1);
    rdc(ADDR_STATUS, {3'h6, trxState});
    pulse(1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, {1'b1, 2'(i), 5'h00});
      ev(reqCyc, 1, 1);
      ex = {1'b1, idle(i, 0, 1, t), 1'b0, trxState};
      rdc(ADDR_STATUS, ex);
    end
    // a frame cut short ends the wait for its run
    pulse(1'b0);
    wr(ADDR_CTRL, 8'hA0);
    ev(reqCyc, 1, 1);
    pulse(1'b1);
    ev(shrCyc, 1, 1);
    rdc(ADDR_STATUS, {3'h6, trxState});
    tally_and_finish();
  end
  // plan needs about 31k cycles; allow over twice that
  initial begin
    #2700000;
    miscompares++;
    tally_and_finish();
  end
endmodule
